// File: src/csel_pkg.sv
// Constants, field layouts and helpers for the status and event logic.
// Assumes a single 20 MHz system clock and a synchronous active-high reset.
package csel_pkg;

  // Clock period and event-pulse time, both in nanoseconds.
  localparam int CLK_PERIOD_NS = 50;
  localparam int EVENT_PULSE_TIME_NS = 1000;
  localparam int EVENT_PULSE_CYCLES = (EVENT_PULSE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Battery-presence debounce time, in nanoseconds.
  localparam int BAT_DEBOUNCE_TIME_NS = 100000;
  localparam int BAT_DEBOUNCE_CYCLES = (BAT_DEBOUNCE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Charge and boost state encodings of the state field.
  localparam logic [3:0] ST_OFF = 4'h0;
  localparam logic [3:0] ST_WAIT = 4'h1;
  localparam logic [3:0] ST_SAFE = 4'h2;
  localparam logic [3:0] ST_VOLTAGE = 4'h5;
  localparam logic [3:0] ST_DONE = 4'h6;
  localparam logic [3:0] ST_DPP = 4'h7;
  localparam logic [3:0] ST_WEAK_WAIT = 4'h8;
  localparam logic [3:0] ST_WEAK_SAFE = 4'h9;
  localparam logic [3:0] ST_WEAK_CHARGE = 4'hA;
  localparam logic [3:0] ST_FAULT = 4'hB;
  localparam logic [3:0] ST_BOOST_SETUP = 4'hC;
  localparam logic [3:0] ST_BOOST_CONFIGURED = 4'hD;
  localparam logic [3:0] ST_BOOST_FAULT = 4'hF;

  // First control register fields and reset value.
  localparam int C1_SOFT_RESET = 7;
  localparam int C1_HOST_BOOST_EN = 5;
  localparam int C1_FACTORY_SEL = 4;
  localparam int C1_DOWNSTREAM_CFG = 2;
  localparam int C1_TIMER_RESET = 1;
  localparam int C1_IRQ_BLOCK = 0;
  localparam logic [7:0] C1_RESET = 8'h55;

  // Second control register fields and reset value.
  localparam int C2_SUPPLY_ROUTE = 5;
  localparam int C2_TRANS_EN = 4;
  localparam logic [7:0] C2_RESET = 8'h16;

  // Interrupt register bit positions.
  localparam int TI_VBUS_OK = 0;
  localparam int C1I_BUCK_OVP = 1;
  localparam int C1I_VIN_HI = 3;
  localparam int C1I_VIN_LO = 4;
  localparam int BI_BAT_RANGE = 0;
  localparam int BI_OVERVOLTAGE = 1;
  localparam int BI_OVERCURRENT = 2;
  localparam int BI_OVERLOAD = 3;

  // Input comparator view bit positions.
  localparam int VS_VCHGDET = 2;
  localparam int VS_VINDET = 3;
  localparam int VS_VBUSUV = 4;
  localparam int VS_BOOST_OVERVOLTAGE_FLAG = 5;
  localparam int VS_VINOVLO = 7;

  localparam logic [7:0] REG_CLEAR = 8'h00;

  function automatic logic is_boost_state(input logic [3:0] st);
    return st[3] & st[2];
  endfunction

  // Active states and wait, but not weak wait, keep the status pin low.
  function automatic logic is_flag_low_state(input logic [3:0] st);
    return (st >= ST_WAIT && st <= ST_VOLTAGE) || st == ST_WEAK_SAFE || st == ST_WEAK_CHARGE;
  endfunction

  function automatic logic is_charging_state(input logic [3:0] st);
    return (st >= ST_SAFE && st <= ST_VOLTAGE) || st == ST_WEAK_SAFE || st == ST_WEAK_CHARGE;
  endfunction

endpackage

// File: src/csel_flag_if.sv
// Carrier between the event logic and the status pin pulser.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ps
interface csel_flag_if;
  logic fire;
  logic stable_low;
  logic busy;
  logic pin_low;
  modport ctrl (output fire, output stable_low, input busy, input pin_low);
  modport pulser (input fire, input stable_low, output busy, output pin_low);
endinterface

// File: src/csel_flag_pulser.sv
// Drives the open-drain status pin: stable level plus inverted event pulses.
// Assumes fire is a one-cycle pulse from logic on the same clock.
`timescale 1ns/1ps
module csel_flag_pulser #(
  parameter int PULSE_CYCLES = csel_pkg::EVENT_PULSE_CYCLES
) (
  input wire logic clk, // System clock.
  input wire logic sys_rst, // Synchronous reset, active high.
  csel_flag_if.pulser flag // Pulse request and pin level.
);
  localparam int CW = $clog2(PULSE_CYCLES + 1);

  initial begin
    if (PULSE_CYCLES < 1) begin
      $error("PULSE_CYCLES must be at least one");
    end
  end

  logic [CW-1:0] count_ff;
  logic pin_low_ff;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      count_ff <= '0;
    end else if (flag.fire && count_ff == '0) begin
      count_ff <= CW'(PULSE_CYCLES);
    end else if (count_ff != '0) begin
      count_ff <= count_ff - 1'b1;
    end
  end

  // The pulse is the inverse of the stable level, so the processor sees an edge either way.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pin_low_ff <= 1'b0;
    end else if (count_ff > CW'(1) || (flag.fire && count_ff == '0)) begin
      pin_low_ff <= ~flag.stable_low;
    end else begin
      pin_low_ff <= flag.stable_low;
    end
  end

  assign flag.busy = (count_ff != '0);
  assign flag.pin_low = pin_low_ff;
endmodule

// File: src/csel_status_event.sv
// Status, flag and status pin logic of a charger with a boost mode.
// Assumes state and timer pulses come from clk logic; comparator and
// select pins are asynchronous and synchronised here.
`timescale 1ns/1ps
// Function
// - Supply on only above undervoltage with enable bit set.
// - Pin low in active states and wait (not weak wait), else high.
// - State field tracks state; each change is an event.
// - Four-bit state field; boost uses 1100, 1101, 1111.
// - Switch presence sampled in off, shown from wait.
// - Summary bits from the status and fault flag registers.
// - Unmasked events pulse the pin against its stable level.
// - State changes and flag bits are sources with own masks.
// - Global block bit suppresses all pin requests.
// - Block bit resets to 1; writing 0 enables.
// - Flags clear on read, set on their active transition.
// - One pulse until all flag registers are clear.
// - Comparator views are live, never latched.
// - Debounced battery removal while charging ends charge.
// - Factory mode when select pin equals select bit.
// - Factory mode locks weak wait, current loops off.
// - Boost starts on request pin or enable bit.
// - Downstream bit 0 precharges, 1 soft-starts the switch.
// - Boost overvoltage stops converter, sets its flag.
// - Output overcurrent opens switch, stops converter, sets flag.
// - Unconfigured boost overload sets the overload flag.
// - Battery out of range stops boost until request toggles.
// - Boost keeps only status and boost flags active.
// - Boost: pin high, low event pulses.
module csel_status_event #(
  parameter int PULSE_CYCLES = csel_pkg::EVENT_PULSE_CYCLES,
  parameter int DEBOUNCE_CYCLES = csel_pkg::BAT_DEBOUNCE_CYCLES
) (
  input wire logic clk, // System clock, 20 MHz.
  input wire logic sys_rst, // Synchronous reset, active high.
  input wire logic [3:0] charge_state, // Present state.
  input wire logic [7:0] vin_cmp, // Input comparator pins.
  input wire logic [7:0] bat_cmp, // Battery comparators; bit 0 overvoltage.
  input wire logic [3:0] temp_cmp, // Thermal comparators: warn, m1, m2, shutdown.
  input wire logic [3:0] boost_cmp, // Boost comparators, flag bit order.
  input wire logic bat_present_pin, // Battery presence comparator pin.
  input wire logic batfet_pin, // Battery switch presence pin.
  input wire logic factory_select_pin, // Factory select pin.
  input wire logic host_boost_pin, // Host boost request pin.
  input wire logic [2:0] timer_expire, // Pulses: charge, usb, watchdog timeouts.
  input wire logic first_control_reg_wr, // First register write strobe.
  input wire logic second_control_reg_wr, // Second register write strobe.
  input wire logic [7:0] ctrl_wdata, // Control write data.
  input wire logic [7:0] temp_input_irq_mask, // Mask, 1 suppresses.
  input wire logic [7:0] charger_mask_a, // Mask, 1 suppresses.
  input wire logic [7:0] charger_mask_b, // Mask, 1 suppresses.
  input wire logic [7:0] boost_irq_mask, // Mask, 1 suppresses.
  input wire logic state_change_mask, // Mask for state change events.
  input wire logic rd_temp_input_irq, // Read pulse, clears the flags.
  input wire logic rd_charger_irq_a, // Read pulse, clears the flags.
  input wire logic rd_charger_irq_b, // Read pulse, clears the flags.
  input wire logic rd_boost_irq, // Read pulse, clears the flags.
  output logic [7:0] status_reg, // State, switch presence, summary bits.
  output logic [7:0] first_control_reg, // First control register.
  output logic [7:0] second_control_reg, // Second control register.
  output logic [7:0] temp_input_irq_reg, // Temperature and input flags.
  output logic [7:0] charger_irq_reg_a, // Charger flags a.
  output logic [7:0] charger_irq_reg_b, // Charger flags b.
  output logic [7:0] boost_irq_reg, // Boost flags.
  output logic [7:0] input_compare_view, // Live input comparators.
  output logic [7:0] battery_compare_view, // Live battery comparators.
  output logic [7:0] thermal_compare_view, // Live thermal comparators.
  output logic trans_supply_en, // Transceiver supply enable.
  output logic factory_mode_active, // Factory mode.
  output logic loops_disable, // Current regulation loops off.
  output logic end_charge_req, // End-of-charge request.
  output logic boost_run, // Boost converter running.
  output logic precharge_en, // Input node precharge source on.
  output logic input_switch_en, // Input switch on.
  output logic input_switch_softstart, // Input switch soft-start.
  output logic flag_pin_out, // Pin drive value, always low.
  output logic flag_pin_oe // Status pin enable, high while pulling low.
);
  localparam int SW = 28;
  localparam int DW = $clog2(DEBOUNCE_CYCLES + 1);

  initial begin
    if (DEBOUNCE_CYCLES < 1) begin
      $error("DEBOUNCE_CYCLES must be at least one");
    end
  end

  // All pins pass two flip-flops; edges compare the second stage with a third.
  logic [SW-1:0] sync1_ff;
  logic [SW-1:0] sync2_ff;
  logic [SW-1:0] prev_ff;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sync1_ff <= '0;
      sync2_ff <= '0;
      prev_ff <= '0;
    end else begin
      sync1_ff <= {host_boost_pin, factory_select_pin, batfet_pin, bat_present_pin,
                   boost_cmp, temp_cmp, bat_cmp, vin_cmp};
      sync2_ff <= sync1_ff;
      prev_ff <= sync2_ff;
    end
  end

  logic [7:0] vin_s;
  logic [7:0] bat_s;
  logic [3:0] temp_s;
  logic [3:0] bst_s;
  logic bat_present_s;
  logic batfet_s;
  logic factory_pin_s;
  logic boost_pin_s;
  assign vin_s = sync2_ff[7:0];
  assign bat_s = sync2_ff[15:8];
  assign temp_s = sync2_ff[19:16];
  assign bst_s = sync2_ff[23:20];
  assign bat_present_s = sync2_ff[24];
  assign batfet_s = sync2_ff[25];
  assign factory_pin_s = sync2_ff[26];
  assign boost_pin_s = sync2_ff[27];

  // Control registers; the soft reset bit restores both.
  logic [7:0] first_control_reg_ff;
  logic [7:0] second_control_reg_ff;
  always_ff @(posedge clk) begin
    if (sys_rst || (first_control_reg_wr && ctrl_wdata[csel_pkg::C1_SOFT_RESET])) begin
      first_control_reg_ff <= csel_pkg::C1_RESET;
    end else if (first_control_reg_wr) begin
      first_control_reg_ff <= ctrl_wdata;
      first_control_reg_ff[csel_pkg::C1_TIMER_RESET] <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst || (first_control_reg_wr && ctrl_wdata[csel_pkg::C1_SOFT_RESET])) begin
      second_control_reg_ff <= csel_pkg::C2_RESET;
    end else if (second_control_reg_wr) begin
      second_control_reg_ff <= ctrl_wdata;
      second_control_reg_ff[3] <= 1'b0;
    end
  end

  logic [3:0] state_ff;
  logic boost_mode;
  assign boost_mode = csel_pkg::is_boost_state(charge_state);

  // Dual-edge flags set on any change, single-edge ones on a rise.
  logic [7:0] ti_evt;
  logic [7:0] c1_evt;
  logic [7:0] c2_evt;
  logic [7:0] bi_evt;
  logic vbus_ok;
  logic vbus_ok_prev;
  logic vin_lo;
  logic vin_lo_prev;
  assign vbus_ok = ~vin_s[csel_pkg::VS_VBUSUV] & ~vin_s[csel_pkg::VS_BOOST_OVERVOLTAGE_FLAG];
  assign vbus_ok_prev = ~prev_ff[csel_pkg::VS_VBUSUV] & ~prev_ff[csel_pkg::VS_BOOST_OVERVOLTAGE_FLAG];
  assign vin_lo = vin_s[csel_pkg::VS_VCHGDET] & ~vin_s[csel_pkg::VS_VINDET];
  assign vin_lo_prev = prev_ff[csel_pkg::VS_VCHGDET] & ~prev_ff[csel_pkg::VS_VINDET];

  always_comb begin
    ti_evt = 8'h00;
    ti_evt[5:2] = temp_s ^ prev_ff[19:16];
    ti_evt[csel_pkg::TI_VBUS_OK] = (vbus_ok ^ vbus_ok_prev) & ~boost_mode;
    c1_evt = 8'h00;
    c1_evt[csel_pkg::C1I_VIN_LO] = vin_lo ^ vin_lo_prev;
    c1_evt[csel_pkg::C1I_VIN_HI] = vin_s[csel_pkg::VS_VINOVLO] ^ prev_ff[csel_pkg::VS_VINOVLO];
    c1_evt[csel_pkg::C1I_BUCK_OVP] = bat_s[0] ^ prev_ff[8];
    c2_evt = 8'h00;
    c2_evt[3:1] = timer_expire;
    bi_evt = 8'h00;
    bi_evt[csel_pkg::BI_BAT_RANGE] = bst_s[0] ^ prev_ff[20];
    bi_evt[csel_pkg::BI_OVERVOLTAGE] = bst_s[1] ^ prev_ff[21];
    bi_evt[csel_pkg::BI_OVERCURRENT] = bst_s[2] & ~prev_ff[22];
    bi_evt[csel_pkg::BI_OVERLOAD] = (bst_s[3] ^ prev_ff[23]) & ~first_control_reg_ff[csel_pkg::C1_DOWNSTREAM_CFG];
  end

  // Flags: a set beats a coincident read clear.
  logic [7:0] ti_ff;
  logic [7:0] c1_ff;
  logic [7:0] c2_ff;
  logic [7:0] bi_ff;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ti_ff <= csel_pkg::REG_CLEAR;
    end else begin
      ti_ff <= (ti_ff & ~{8{rd_temp_input_irq}}) | ti_evt;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst || boost_mode) begin
      c1_ff <= csel_pkg::REG_CLEAR;
      c2_ff <= csel_pkg::REG_CLEAR;
    end else begin
      c1_ff <= (c1_ff & ~{8{rd_charger_irq_a}}) | c1_evt;
      c2_ff <= (c2_ff & ~{8{rd_charger_irq_b}}) | c2_evt;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst || !boost_mode) begin
      bi_ff <= csel_pkg::REG_CLEAR;
    end else begin
      bi_ff <= (bi_ff & ~{8{rd_boost_irq}}) | bi_evt;
    end
  end

  // State change detection.
  logic state_evt;
  assign state_evt = (charge_state != state_ff);
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_ff <= csel_pkg::ST_OFF;
    end else begin
      state_ff <= charge_state;
    end
  end

  // Switch presence is caught in off and shown from wait onward.
  logic batfet_ff;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      batfet_ff <= 1'b0;
    end else if (charge_state == csel_pkg::ST_OFF) begin
      batfet_ff <= batfet_s;
    end
  end

  logic any_pending;
  logic unmasked_evt;
  assign any_pending = (|ti_ff) | (|c1_ff) | (|c2_ff) | (|bi_ff);
  assign unmasked_evt = (state_evt & ~state_change_mask)
                      | (|(ti_evt & ~temp_input_irq_mask))
                      | (|(c1_evt & ~charger_mask_a) & ~boost_mode)
                      | (|(c2_evt & ~charger_mask_b) & ~boost_mode)
                      | (|(bi_evt & ~boost_irq_mask) & boost_mode);

  // One pulse per burst: rearmed only once every flag register reads back empty.
  logic armed_ff;
  logic fire;
  csel_flag_if flag_bus ();
  assign fire = armed_ff & unmasked_evt & ~first_control_reg_ff[csel_pkg::C1_IRQ_BLOCK];
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      armed_ff <= 1'b1;
    end else if (fire) begin
      armed_ff <= 1'b0;
    end else if (!any_pending && !flag_bus.busy) begin
      armed_ff <= 1'b1;
    end
  end

  assign flag_bus.fire = fire;
  assign flag_bus.stable_low = csel_pkg::is_flag_low_state(charge_state) & ~boost_mode;

  csel_flag_pulser #(
    .PULSE_CYCLES(PULSE_CYCLES)
  ) u_pulser (
    .clk(clk),
    .sys_rst(sys_rst),
    .flag(flag_bus)
  );

  // Removal acts only after the debounce time, bridging bounces.
  logic [DW-1:0] deb_cnt_ff;
  logic bat_deb_ff;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      deb_cnt_ff <= '0;
      bat_deb_ff <= 1'b1;
    end else if (bat_present_s == bat_deb_ff) begin
      deb_cnt_ff <= '0;
    end else if (deb_cnt_ff == DW'(DEBOUNCE_CYCLES - 1)) begin
      deb_cnt_ff <= '0;
      bat_deb_ff <= bat_present_s;
    end else begin
      deb_cnt_ff <= deb_cnt_ff + 1'b1;
    end
  end

  // Boost request, fault lockout and start-up path.
  logic boost_req;
  logic boost_req_prev_ff;
  logic lockout_ff;
  logic boost_fault;
  assign boost_req = boost_pin_s | first_control_reg_ff[csel_pkg::C1_HOST_BOOST_EN];
  assign boost_fault = boost_mode & (bst_s[0] | bst_s[1] | bst_s[2]);
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      lockout_ff <= 1'b0;
      boost_req_prev_ff <= 1'b0;
    end else begin
      boost_req_prev_ff <= boost_req;
      if (boost_fault) begin
        lockout_ff <= 1'b1;
      end else if (!boost_req) begin
        lockout_ff <= 1'b0;
      end
    end
  end

  // Registered outputs.
  logic factory_mode;
  logic input_low;
  assign factory_mode = (factory_pin_s == first_control_reg_ff[csel_pkg::C1_FACTORY_SEL]);
  assign input_low = vin_s[csel_pkg::VS_VBUSUV];

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      trans_supply_en <= 1'b0;
      factory_mode_active <= 1'b0;
      loops_disable <= 1'b0;
      end_charge_req <= 1'b0;
    end else begin
      trans_supply_en <= ~input_low & second_control_reg_ff[csel_pkg::C2_TRANS_EN];
      factory_mode_active <= factory_mode;
      loops_disable <= factory_mode;
      end_charge_req <= ~bat_deb_ff & batfet_ff & second_control_reg_ff[csel_pkg::C2_SUPPLY_ROUTE]
                        & csel_pkg::is_charging_state(charge_state);
    end
  end

  logic run;
  assign run = boost_req & ~lockout_ff & ~boost_fault & ~factory_mode;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      boost_run <= 1'b0;
      precharge_en <= 1'b0;
      input_switch_en <= 1'b0;
      input_switch_softstart <= 1'b0;
    end else begin
      boost_run <= run;
      precharge_en <= run & ~first_control_reg_ff[csel_pkg::C1_DOWNSTREAM_CFG];
      input_switch_en <= run & first_control_reg_ff[csel_pkg::C1_DOWNSTREAM_CFG];
      input_switch_softstart <= run & first_control_reg_ff[csel_pkg::C1_DOWNSTREAM_CFG]
                                & ~boost_req_prev_ff;
    end
  end

  // Views; comparators one flop behind the synchroniser, never held.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      status_reg <= 8'h00;
      temp_input_irq_reg <= 8'h00;
      charger_irq_reg_a <= 8'h00;
      charger_irq_reg_b <= 8'h00;
      boost_irq_reg <= 8'h00;
      input_compare_view <= 8'h00;
      battery_compare_view <= 8'h00;
      thermal_compare_view <= 8'h00;
      first_control_reg <= csel_pkg::C1_RESET;
      second_control_reg <= csel_pkg::C2_RESET;
      flag_pin_oe <= 1'b0;
    end else begin
      status_reg <= {charge_state, batfet_ff & (charge_state != csel_pkg::ST_OFF), 1'b0,
                     |ti_ff, (|c1_ff) | (|c2_ff) | (|bi_ff)};
      temp_input_irq_reg <= ti_ff;
      charger_irq_reg_a <= {c1_ff[7:1], |c2_ff[7:1]};
      charger_irq_reg_b <= {c2_ff[7:1], |c1_ff[7:1]};
      boost_irq_reg <= bi_ff;
      input_compare_view <= vin_s & 8'hBC;
      battery_compare_view <= bat_s;
      thermal_compare_view <= {4'h0, temp_s};
      first_control_reg <= first_control_reg_ff;
      second_control_reg <= second_control_reg_ff;
      flag_pin_oe <= flag_bus.pin_low;
    end
  end

  assign flag_pin_out = 1'b0;
endmodule

// File: testbench/csel_status_event_asserts.sv
// Concurrent checks on the ports of the status and event block.
// Assumes one clock domain; bound below to every instance.
`timescale 1ns/1ps
module csel_status_event_asserts #(
  parameter int PULSE_CYCLES = 4,
  parameter int DEBOUNCE_CYCLES = 8
) (
  input wire logic clk, // System clock.
  input wire logic sys_rst, // Synchronous reset.
  input wire logic [3:0] charge_state, // Present state.
  input wire logic [7:0] vin_cmp, // Input comparators.
  input wire logic [3:0] boost_cmp, // Boost comparators.
  input wire logic factory_select_pin, // Factory pin.
  input wire logic [7:0] status_reg, // Status.
  input wire logic [7:0] first_control_reg, // First control.
  input wire logic [7:0] temp_input_irq_reg, // Flags.
  input wire logic [7:0] charger_irq_reg_a, // Flags.
  input wire logic [7:0] charger_irq_reg_b, // Flags.
  input wire logic [7:0] boost_irq_reg, // Flags.
  input wire logic trans_supply_en, // Supply enable.
  input wire logic factory_mode_active, // Factory mode.
  input wire logic boost_run, // Converter on.
  input wire logic flag_pin_oe // Pin pulled low.
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic [7:0] hi_cnt_ff;
  logic [7:0] nxt_hi_cnt;
  logic in_boost;
  assign in_boost = status_reg[7:6] == 2'b11;
  // Length of the present pull-low run.
  assign nxt_hi_cnt = flag_pin_oe ? hi_cnt_ff + 8'h01 : 8'h00;
  always_ff @(posedge clk) begin
    hi_cnt_ff <= sys_rst ? 8'h00 : nxt_hi_cnt;
  end
  AST_TRANS_UV: assert property (vin_cmp[4] [*5] |-> !trans_supply_en)
    else $error("Supply on below undervoltage");
  AST_STATE_FIELD: assert property ($stable(charge_state) [*3] |-> status_reg[7:4] == charge_state)
    else $error("State field differs from state");
  AST_SUM_STATUS: assert property (status_reg[1] == (temp_input_irq_reg != 8'h00))
    else $error("Status summary wrong");
  AST_SUM_FAULT: assert property (status_reg[0] == ((charger_irq_reg_a | charger_irq_reg_b | boost_irq_reg) != 8'h00))
    else $error("Fault summary wrong");
  AST_FACTORY: assert property (($stable(factory_select_pin) && $stable(first_control_reg[4])) [*5]
    |-> factory_mode_active == (factory_select_pin == first_control_reg[4]))
    else $error("Factory mode wrong");
  AST_BOOST_HIGH: assert property (in_boost [*3] ##0 flag_pin_oe |-> hi_cnt_ff < PULSE_CYCLES)
    else $error("Pin held low in boost");
  AST_PULSE_LEN: assert property ($fell(flag_pin_oe) && in_boost |-> hi_cnt_ff == PULSE_CYCLES)
    else $error("Pulse width wrong");
  AST_BOOST_CLR: assert property (in_boost [*3] |-> (charger_irq_reg_a | charger_irq_reg_b) == 8'h00)
    else $error("Charger flags active in boost");
  AST_BOOST_OV: assert property ((in_boost && boost_cmp[1]) [*5] |-> !boost_run)
    else $error("Converter runs on overvoltage");
  CV_PULSE: cover property ($fell(flag_pin_oe) && in_boost);
  CV_STOP: cover property (boost_run ##1 !boost_run);
  CV_FACTORY: cover property (factory_mode_active);
endmodule
bind csel_status_event csel_status_event_asserts #(.PULSE_CYCLES(PULSE_CYCLES), .DEBOUNCE_CYCLES(DEBOUNCE_CYCLES))
  csel_status_event_asserts_inst (.clk, .sys_rst, .charge_state, .vin_cmp, .boost_cmp, .factory_select_pin,
  .status_reg, .first_control_reg, .temp_input_irq_reg, .charger_irq_reg_a, .charger_irq_reg_b, .boost_irq_reg,
  .trans_supply_en, .factory_mode_active, .boost_run, .flag_pin_oe);

// File: testbench/csel_host_model.sv
// Processor side: pulled-up status wire and read-to-clear strobes.
// Assumes the status pin is open drain with an external pull-up.
`timescale 1ns/1ps
module csel_host_model (
  input wire logic clk, // System clock.
  input wire logic flag_pin_out, // Pin drive value.
  input wire logic flag_pin_oe, // Pin drive enable.
  input wire logic clear_req, // Ask to read all flag registers.
  output logic flag_wire, // Resolved pin level.
  output logic rd_all // One-cycle read of every flag register.
);
  assign flag_wire = flag_pin_oe ? flag_pin_out : 1'b1;
  initial rd_all = 1'b0;
  // Reading all flags rearms a flag pulse; a state-change pulse with no flags set rearms alone.
  always @(posedge clk) begin
    rd_all <= clear_req && !rd_all;
  end
endmodule

// File: testbench/charger_status_event_logic_test.sv
// Self-checking bench for the status and event block.
// Assumes the host model resolves the pin and reads the flags.
`timescale 1ns/1ps
module charger_status_event_logic_test;
  localparam int PULSE = 4;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [3:0] charge_state = 4'h0, temp_cmp = 4'h0, boost_cmp = 4'h0;
  logic [7:0] vin_cmp = 8'h00, bat_cmp = 8'h00, ctrl_wdata = 8'h00;
  logic [7:0] temp_input_irq_mask = 8'h00, charger_mask_a = 8'h00, charger_mask_b = 8'h00;
  logic [2:0] timer_expire = 3'h0;
  logic bat_present_pin = 1'b0, batfet_pin = 1'b0, factory_select_pin = 1'b0, host_boost_pin = 1'b0;
  logic first_control_reg_wr = 1'b0, second_control_reg_wr = 1'b0, state_change_mask = 1'b1, clr = 1'b0;
  logic [7:0] status_reg, first_control_reg, second_control_reg, temp_input_irq_reg, charger_irq_reg_a;
  logic [7:0] boost_irq_reg, battery_compare_view;
  logic trans_supply_en, factory_mode_active, loops_disable, boost_run, flag_pin_out, flag_pin_oe, fw, rd;
  logic [31:0] seed = 32'h6A0A, error_cnt = 32'h0, cmp_count = 32'h0, cyc = 32'h0, run = 32'h1;
  logic cur = 1'b1, prv = 1'b1;
  logic [31:0] exp_q[$];
  csel_status_event #(.PULSE_CYCLES(PULSE), .DEBOUNCE_CYCLES(8)) csel_status_event_inst (.clk, .sys_rst,
    .charge_state, .vin_cmp, .bat_cmp, .temp_cmp, .boost_cmp, .bat_present_pin, .batfet_pin, .factory_select_pin,
    .host_boost_pin, .timer_expire, .first_control_reg_wr, .second_control_reg_wr, .ctrl_wdata,
    .temp_input_irq_mask, .charger_mask_a, .charger_mask_b, .boost_irq_mask(8'h00), .state_change_mask,
    .rd_temp_input_irq(rd), .rd_charger_irq_a(rd), .rd_charger_irq_b(rd), .rd_boost_irq(rd), .status_reg,
    .first_control_reg, .second_control_reg, .temp_input_irq_reg, .charger_irq_reg_a, .charger_irq_reg_b(),
    .boost_irq_reg, .input_compare_view(), .battery_compare_view, .thermal_compare_view(), .trans_supply_en,
    .factory_mode_active, .loops_disable, .end_charge_req(), .boost_run, .precharge_en(), .input_switch_en(),
    .input_switch_softstart(), .flag_pin_out, .flag_pin_oe);
  csel_host_model csel_host_model_inst (.clk, .flag_pin_out, .flag_pin_oe, .clear_req(clr), .flag_wire(fw),
    .rd_all(rd));
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wr(input logic sel, input logic [7:0] d);
    @(posedge clk);
    first_control_reg_wr <= !sel;
    second_control_reg_wr <= sel;
    ctrl_wdata <= d;
    @(posedge clk);
    first_control_reg_wr <= 1'b0;
    second_control_reg_wr <= 1'b0;
    tick(3);
  endtask
  task automatic clear_all;
    @(posedge clk);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    tick(4);
  endtask
  task summarize;
    $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    forever #25 clk = ~clk;
  end
  // A short run back to the former level is a pulse.
  always @(posedge clk) begin
    cyc <= cyc + 32'h1;
    if (cyc == 32'h1388) begin
      error_cnt++;
      summarize();
    end
    if (sys_rst) begin
      run <= 32'h1;
    end else if (fw !== cur) begin
      if (fw === prv && run < 32'h8) chk(run, exp_q.size() ? exp_q.pop_front() : 32'h0);
      prv <= cur;
      cur <= fw;
      run <= 32'h1;
    end else begin
      run <= run + 32'h1;
    end
  end
  initial begin
    tick(6);
    sys_rst <= 1'b0;
    tick(2);
    chk(first_control_reg, 8'h55);
    chk(second_control_reg, 8'h16);
    chk(fw, 1'b1);
    for (int i = 0; i < 3; i++) begin
      seed = xs(seed);
      @(posedge clk);
      {charger_mask_b, charger_mask_a, temp_input_irq_mask, bat_cmp} <= seed;
      {batfet_pin, bat_present_pin, timer_expire} <= seed[4:0];
      @(posedge clk);
      timer_expire <= 3'h0;
      tick(4);
      chk(battery_compare_view, bat_cmp);
    end
    {charger_mask_b, charger_mask_a, temp_input_irq_mask} <= 24'h0;
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      factory_select_pin <= i[0] ^ i[1];
      wr(1'b0, 8'h45 | {3'h0, i[1], 4'h0});
      chk(factory_mode_active, !i[0]);
      chk(loops_disable, !i[0]);
    end
    wr(1'b1, 8'h16);
    chk(trans_supply_en, 1'b1);
    vin_cmp <= 8'h10;
    tick(6);
    chk(trans_supply_en, 1'b0);
    vin_cmp <= 8'h00;
    wr(1'b1, 8'h06);
    chk(trans_supply_en, 1'b0);
    clear_all();
    wr(1'b0, 8'h54);
    charge_state <= 4'h3;
    tick(8);
    chk(fw, 1'b0);
    exp_q.push_back(PULSE);
    temp_cmp <= 4'h9;
    tick(12);
    chk(temp_input_irq_reg, 8'h24);
    chk(status_reg[1:0], 2'b10);
    vin_cmp <= 8'h80;
    tick(12);
    chk(status_reg[1:0], 2'b11);
    clear_all();
    chk(temp_input_irq_reg | charger_irq_reg_a, 8'h00);
    exp_q.push_back(PULSE);
    temp_cmp <= 4'hB;
    tick(12);
    clear_all();
    temp_input_irq_mask <= 8'h10;
    temp_cmp <= 4'hF;
    tick(12);
    chk(temp_input_irq_reg, 8'h10);
    clear_all();
    charge_state <= 4'h0;
    tick(6);
    state_change_mask <= 1'b0;
    host_boost_pin <= 1'b1;
    tick(8);
    chk(boost_run, 1'b1);
    exp_q.push_back(PULSE);
    charge_state <= 4'hC;
    tick(12);
    chk(status_reg[7:4], 4'hC);
    chk(fw, 1'b1);
    clear_all();
    exp_q.push_back(PULSE);
    boost_cmp <= 4'h2;
    tick(12);
    chk(boost_run, 1'b0);
    chk(boost_irq_reg, 8'h02);
    chk(charger_irq_reg_a, 8'h00);
    chk(exp_q.size(), 32'h0);
    summarize();
  end
endmodule
